/* File: afepg_pkg.sv */
// ============================================================
// shared constants for the phase, gain and status register bank
package afepg_pkg;
    // register addresses
    localparam logic [4:0] PHASE_ADDR = 5'h0a;
    localparam logic [4:0] GAIN_ADDR = 5'h0b;
    localparam logic [4:0] STATUS_ADDR = 5'h0c;
    // burst address loop masks and writable window
    localparam logic [4:0] LOOP_MAP_MASK = 5'h1f;
    localparam logic [4:0] LOOP_TYPE_MASK = 5'h0f;
    localparam logic [4:0] LOOP_GROUP_MASK = 5'h03;
    localparam logic [4:0] WR_LOOP_FIRST = 5'h09;
    localparam logic [4:0] WR_LOOP_LAST = 5'h1f;
    // phase register fields
    localparam int PAIR23_LSB = 12;
    localparam int PAIR01_LSB = 0;
    // gain register fields
    localparam int GAIN_BITS = 3;
    localparam logic [2:0] GAIN_MAX_CODE = 3'h5;
    // status register fields
    localparam int RDINC_LSB = 22;
    localparam int WRINC_BIT = 21;
    localparam int IDLE_DRIVE_BIT = 20;
    localparam int MERGE_BIT = 19;
    localparam int CRC32_BIT = 18;
    localparam int DWIDTH_LSB = 16;
    localparam int CRC_EN_BIT = 15;
    localparam int ALERT_EN_BIT = 14;
    // read increment modes
    localparam logic [1:0] RDINC_SAME = 2'h0;
    localparam logic [1:0] RDINC_GROUP = 2'h1;
    localparam logic [1:0] RDINC_TYPE = 2'h2;
    localparam logic [1:0] RDINC_MAP = 2'h3;
    // data width modes
    localparam logic [1:0] DW_16_ROUND = 2'h0;
    localparam logic [1:0] DW_24 = 2'h1;
    localparam logic [1:0] DW_32_ZERO = 2'h2;
    localparam logic [1:0] DW_32_SIGN = 2'h3;
    // reset values
    localparam logic [23:0] PHASE_RESET = 24'h000000;
    localparam logic [23:0] GAIN_RESET = 24'h000000;
    localparam logic [9:0] SETUP_RESET = 10'h2a4; // bits 23..14
    localparam logic [5:0] FLAGS_RESET = 6'h3f;
    // lock password that clears the checksum alert
    localparam logic [7:0] UNLOCK_KEY = 8'ha5;
    // ready pin pulse length
    localparam int READY_PULSE_CYCLES = 1;
    // ready pin states
    typedef enum logic [2:0] {
        PIN_IDLE = 3'b001,
        PIN_PULSE = 3'b010,
        PIN_ALERT = 3'b100
    } afepg_pin_type;
endpackage

/* File: afepg_fifo.sv */
`timescale 1ns/1ps
// ============================================================
// sample word fifo, flip-flop storage
module afepg_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // honest full and empty
    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data = mem_q[rd_ptr_q];

    // pointer wrap helper
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    // storage write
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) wr_ptr_q <= bump(wr_ptr_q);
            if (pop) rd_ptr_q <= bump(rd_ptr_q);
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* File: afepg_regs.sv */
`timescale 1ns/1ps
// Overview of operation
// - a write to the pair phase register restarts all active converters
// - pair 2/3 delay code sits in bits 23..12, modulator clock periods
// - pair 0/1 delay code sits in bits 11..0, modulator clock periods
// - three-bit gain code per channel in bits 17..0, gains 1 to 32
// - reserved gain codes 110 and 111 act as gain 1
// - gain register bits 23..18 always read zero
// - read increment field picks same, group, type or whole-map looping
// - write increment bit loops writable map or repeats one address
// - idle ready pin drives high when bit set, floats when clear
// - merge bit gives one pulse timed by the last channel
// - crc width bit sends checksum plus sixteen zeros as 32 bits
// - data width field formats samples 32 sign, 32 zero, 24, 16 rounded
// - status bits 13..6 read zero, ready flags read-only reset to one
// - ready flag zero when data ready, set to one by status read
// - checksum enable bit appends crc to each transfer, resets off
// - alert enable drives ready pin low on checksum error until unlocked
module afepg_regs #(
    parameter int CHANNELS = 6,
    parameter int SAMPLE_WIDTH = 24,
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register access
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [4:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    output logic [23:0] reg_rdata,
    output logic reg_rvalid,
    output logic [4:0] burst_next_addr,
    // converter controls
    output logic restart_active_adcs,
    output logic [11:0] pair23_delay_code,
    output logic [11:0] pair01_delay_code,
    output logic [17:0] channel_gain_code,
    output logic [17:0] channel_gain_log2,
    // serial formatting controls
    output logic comm_checksum_enable,
    output logic crc_word_32,
    // converter events and checksum alert inputs
    input wire logic [5:0] chan_ready_pulse,
    input wire logic config_checksum_error,
    input wire logic [7:0] lock_code,
    // sample stream in
    input wire logic sample_in_valid,
    output logic sample_in_ready,
    input wire logic [SAMPLE_WIDTH-1:0] sample_in_data,
    // formatted sample stream out
    output logic sample_out_valid,
    input wire logic sample_out_ready,
    output logic [31:0] sample_out_data,
    // ready pin
    output logic sample_ready_pin_o,
    output logic sample_ready_pin_oe
);
    // ============================================================
    // registers
    logic [23:0] phase_q;
    logic [23:0] gain_q;
    logic [9:0] setup_q;
    logic [5:0] flags_q;
    logic [5:0] flags_d;
    logic [23:0] rdata_q;
    logic rvalid_q;
    logic restart_q;
    logic [4:0] burst_q;

    // ============================================================
    // decode
    wire wr_phase = reg_wr_en && (reg_addr == afepg_pkg::PHASE_ADDR);
    wire wr_gain = reg_wr_en && (reg_addr == afepg_pkg::GAIN_ADDR);
    wire wr_status = reg_wr_en && (reg_addr == afepg_pkg::STATUS_ADDR);
    wire rd_status = reg_rd_en && (reg_addr == afepg_pkg::STATUS_ADDR);

    // setup fields
    wire [1:0] rd_inc_mode = setup_q[afepg_pkg::RDINC_LSB-14 +: 2];
    wire wr_inc_on = setup_q[afepg_pkg::WRINC_BIT-14];
    wire idle_drive_high = setup_q[afepg_pkg::IDLE_DRIVE_BIT-14];
    wire ready_pulse_merge = setup_q[afepg_pkg::MERGE_BIT-14];
    wire [1:0] data_width_mode = setup_q[afepg_pkg::DWIDTH_LSB-14 +: 2];
    wire alert_enable = setup_q[afepg_pkg::ALERT_EN_BIT-14];

    // ============================================================
    // helpers
    function automatic logic [4:0] loop_next(input logic [4:0] a, input logic [4:0] m);
        logic [4:0] inc;
        inc = 5'(a + 5'h01);
        loop_next = (a & ~m) | (inc & m);
    endfunction

    function automatic logic [2:0] gain_log2(input logic [2:0] code);
        gain_log2 = (code > afepg_pkg::GAIN_MAX_CODE) ? 3'h0 : code;
    endfunction

    function automatic logic [31:0] format_sample(input logic [1:0] mode,
                                                  input logic [23:0] s);
        logic [16:0] rnd;
        rnd = 17'({s[23], s[23:8]} + 17'(s[7]));
        case (mode)
            afepg_pkg::DW_32_SIGN: format_sample = {{8{s[23]}}, s};
            afepg_pkg::DW_32_ZERO: format_sample = {s, 8'h00};
            afepg_pkg::DW_24: format_sample = {8'h00, s};
            default: begin
                // saturate on positive overflow of the rounding
                if (!s[23] && rnd[15]) format_sample = {16'h0000, 16'h7fff};
                else format_sample = {16'h0000, rnd[15:0]};
            end
        endcase
    endfunction

    // ============================================================
    // read mux and burst address
    wire [23:0] setup_view = {setup_q, 2'b00, 6'h00, flags_q};
    wire [23:0] rd_mux =
        (reg_addr == afepg_pkg::PHASE_ADDR) ? phase_q :
        (reg_addr == afepg_pkg::GAIN_ADDR) ? {6'h00, gain_q[17:0]} :
        (reg_addr == afepg_pkg::STATUS_ADDR) ? setup_view : 24'h000000;
    wire [4:0] rd_mask =
        (rd_inc_mode == afepg_pkg::RDINC_MAP) ? afepg_pkg::LOOP_MAP_MASK :
        (rd_inc_mode == afepg_pkg::RDINC_TYPE) ? afepg_pkg::LOOP_TYPE_MASK :
        (rd_inc_mode == afepg_pkg::RDINC_GROUP) ? afepg_pkg::LOOP_GROUP_MASK : 5'h00;
    wire wr_wrap = (reg_addr >= afepg_pkg::WR_LOOP_LAST) || (reg_addr < afepg_pkg::WR_LOOP_FIRST);
    wire [4:0] wr_next = !wr_inc_on ? reg_addr :
        (wr_wrap ? afepg_pkg::WR_LOOP_FIRST : 5'(reg_addr + 5'h01));

    // ready flags: a converter event wins over the read that resets them
    assign flags_d = (rd_status ? afepg_pkg::FLAGS_RESET : flags_q) & ~chan_ready_pulse;

    // register writes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase_q <= afepg_pkg::PHASE_RESET;
            gain_q <= afepg_pkg::GAIN_RESET;
            setup_q <= afepg_pkg::SETUP_RESET;
            flags_q <= afepg_pkg::FLAGS_RESET;
        end else begin
            if (wr_phase) phase_q <= reg_wdata;
            if (wr_gain) gain_q <= {6'h00, reg_wdata[17:0]};
            if (wr_status) setup_q <= reg_wdata[23:14];
            flags_q <= flags_d;
        end
    end

    // read data, restart strobe, burst address
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_q <= 24'h000000;
            rvalid_q <= 1'b0;
            restart_q <= 1'b0;
            burst_q <= 5'h00;
        end else begin
            rvalid_q <= reg_rd_en;
            if (reg_rd_en) rdata_q <= rd_mux;
            restart_q <= wr_phase;
            if (reg_rd_en) burst_q <= loop_next(reg_addr, rd_mask);
            else if (reg_wr_en) burst_q <= wr_next;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign burst_next_addr = burst_q;
    assign restart_active_adcs = restart_q;
    assign pair23_delay_code = phase_q[afepg_pkg::PAIR23_LSB +: 12];
    assign pair01_delay_code = phase_q[afepg_pkg::PAIR01_LSB +: 12];
    assign channel_gain_code = gain_q[17:0];
    assign comm_checksum_enable = setup_q[afepg_pkg::CRC_EN_BIT-14];
    assign crc_word_32 = setup_q[afepg_pkg::CRC32_BIT-14];

    // per-channel gain shift
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_gain
            assign channel_gain_log2[gi*3 +: 3] = gain_log2(gain_q[gi*3 +: 3]);
        end
    endgenerate

    // ============================================================
    // sample path
    logic fifo_valid;
    logic [SAMPLE_WIDTH-1:0] fifo_data;
    afepg_fifo #(.WIDTH(SAMPLE_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(sample_in_valid),
        .in_ready(sample_in_ready),
        .in_data(sample_in_data),
        .out_valid(fifo_valid),
        .out_ready(sample_out_ready),
        .out_data(fifo_data)
    );
    assign sample_out_valid = fifo_valid;
    assign sample_out_data = format_sample(data_width_mode, fifo_data[23:0]);

    // ============================================================
    // ready pin
    afepg_pkg::afepg_pin_type pin_q;
    afepg_pkg::afepg_pin_type pin_d;
    logic [5:0] seen_q;
    logic alert_q;
    logic [7:0] pulse_cnt_q;
    wire [5:0] seen_all = seen_q | chan_ready_pulse;
    wire merged_fire = ready_pulse_merge && (seen_all == afepg_pkg::FLAGS_RESET);
    wire single_fire = !ready_pulse_merge && (chan_ready_pulse != 6'h00);
    wire fire = merged_fire || single_fire;
    wire unlock = (lock_code == afepg_pkg::UNLOCK_KEY);
    wire pulse_done = (pulse_cnt_q == 8'(afepg_pkg::READY_PULSE_CYCLES - 1));

    // merge tracker and alert latch
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            seen_q <= 6'h00;
            alert_q <= 1'b0;
        end else begin
            seen_q <= (merged_fire || !ready_pulse_merge) ? 6'h00 : seen_all;
            if (alert_enable && config_checksum_error) alert_q <= 1'b1;
            else if (unlock) alert_q <= 1'b0;
        end
    end

    // pin state choice
    always_comb begin
        pin_d = pin_q;
        case (pin_q)
            afepg_pkg::PIN_IDLE: if (fire) pin_d = afepg_pkg::PIN_PULSE;
            afepg_pkg::PIN_PULSE:
                if (pulse_done) pin_d = afepg_pkg::PIN_IDLE;
            afepg_pkg::PIN_ALERT: pin_d = afepg_pkg::PIN_IDLE;
            default: pin_d = afepg_pkg::PIN_IDLE;
        endcase
        if (alert_q) pin_d = afepg_pkg::PIN_ALERT;
    end

    // pin state and pulse counter
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_q <= afepg_pkg::PIN_IDLE;
            pulse_cnt_q <= 8'h00;
        end else begin
            pin_q <= pin_d;
            pulse_cnt_q <= (pin_q == afepg_pkg::PIN_PULSE) ? 8'(pulse_cnt_q + 8'h01) : 8'h00;
        end
    end

    wire pin_low = (pin_q != afepg_pkg::PIN_IDLE);
    assign sample_ready_pin_o = !pin_low;
    assign sample_ready_pin_oe = pin_low || idle_drive_high;

    // ============================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_phase_restart: assert property (wr_phase |=> restart_active_adcs)
        else $error("phase write did not restart converters");
    a_no_spurious_restart: assert property (!wr_phase |=> !restart_active_adcs)
        else $error("restart without phase write");
    a_pair23_field: assert property (wr_phase |=>
        pair23_delay_code == $past(reg_wdata[23:12]))
        else $error("pair 2/3 delay code wrong");
    a_pair01_field: assert property (wr_phase |=>
        pair01_delay_code == $past(reg_wdata[11:0]))
        else $error("pair 0/1 delay code wrong");
    a_gain_reserved: assert property (wr_gain && reg_wdata[2:1] == 2'b11 |=>
        channel_gain_log2[2:0] == 3'h0)
        else $error("reserved gain code not treated as gain 1");
    a_gain_upper_zero: assert property (reg_rd_en &&
        reg_addr == afepg_pkg::GAIN_ADDR |=> reg_rdata[23:18] == 6'h00)
        else $error("gain upper bits not zero");
    a_status_reserved: assert property (rd_status |=> reg_rdata[13:6] == 8'h00)
        else $error("status reserved bits not zero");
    a_flag_event_wins: assert property (chan_ready_pulse[0] |=> !flags_q[0])
        else $error("ready event lost");
    a_flag_status_read: assert property (rd_status && chan_ready_pulse == 6'h00 |=>
        flags_q == 6'h3f)
        else $error("status read did not reset flags");
    a_rd_same_addr: assert property (reg_rd_en &&
        rd_inc_mode == afepg_pkg::RDINC_SAME |=> burst_next_addr == $past(reg_addr))
        else $error("read burst address moved");
    a_wr_same_addr: assert property (reg_wr_en && !reg_rd_en && !wr_inc_on |=>
        burst_next_addr == $past(reg_addr))
        else $error("write burst address moved");
    a_idle_float: assert property (pin_q == afepg_pkg::PIN_IDLE && !idle_drive_high |->
        !sample_ready_pin_oe)
        else $error("idle ready pin driven while floating");
    a_single_pulse: assert property (single_fire && !alert_q &&
        pin_q == afepg_pkg::PIN_IDLE |=> !sample_ready_pin_o ##1 (sample_ready_pin_o || alert_q))
        else $error("ready pulse shape wrong");
    a_merge_wait: assert property (ready_pulse_merge && !merged_fire && !alert_q &&
        pin_q == afepg_pkg::PIN_IDLE |=> sample_ready_pin_o)
        else $error("merged ready pulse fired early");
    a_alert_hold: assert property (alert_q && !unlock |=> alert_q ##1 !sample_ready_pin_o)
        else $error("alert not held low");
    a_width_24: assert property (sample_out_valid &&
        data_width_mode == afepg_pkg::DW_24 |-> sample_out_data[31:24] == 8'h00)
        else $error("24-bit format not padded");
    a_width_sign: assert property (sample_out_valid &&
        data_width_mode == afepg_pkg::DW_32_SIGN |->
        sample_out_data[31:24] == {8{sample_out_data[23]}})
        else $error("32-bit format not sign extended");
    a_width_zero: assert property (sample_out_valid &&
        data_width_mode == afepg_pkg::DW_32_ZERO |-> sample_out_data[7:0] == 8'h00)
        else $error("32-bit format not zero padded");
    a_crc_enable: assert property (wr_status |=>
        comm_checksum_enable == $past(reg_wdata[15]))
        else $error("checksum enable bit not stored");
    a_crc_width: assert property (wr_status |=> crc_word_32 == $past(reg_wdata[18]))
        else $error("crc width bit not stored");

    c_merged_pulse: cover property (merged_fire);
    c_alert_clear: cover property (alert_q ##1 !alert_q);
    c_fifo_full: cover property (!sample_in_ready);
    c_status_read_race: cover property (rd_status && chan_ready_pulse != 6'h00);
    c_single_pulse: cover property (single_fire ##1 !sample_ready_pin_o);
endmodule

/* File: afepg_host_model.sv */
`timescale 1ns/1ps
// ============================================================
// host side of the register access, changes on the falling edge
module afepg_host_model (
    // clock
    input wire logic sys_clk,
    // register access
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [4:0] reg_addr,
    output logic [23:0] reg_wdata,
    input wire logic [23:0] reg_rdata,
    input wire logic reg_rvalid
);
    // idle bus values at time zero
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 24'h000000;
    end
    // one word write; stale address and data are inverted afterwards
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // one word read; answer taken in the cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [23:0] d, output logic v);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge sys_clk);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        v = reg_rvalid;
        d = reg_rdata;
    endtask
endmodule

/* File: afe_phase_gain_status_regs_test.sv */
`timescale 1ns/1ps
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t %s", $time, m); end end
// ============================================================
// self-checking bench with a behavioural register and sample model
module afe_phase_gain_status_regs_test;
    logic sys_clk, rst, reg_wr_en, reg_rd_en, reg_rvalid, restart, crc_en, crc32;
    logic [4:0] reg_addr, burst_next_addr;
    logic [23:0] reg_wdata, reg_rdata, rdv, d, s;
    logic [11:0] p23, p01;
    logic [17:0] gcode, glog, g, lg;
    logic [5:0] chan_ready_pulse, flags_m;
    logic err_in, in_valid, in_ready, out_valid, out_ready, pin_o, pin_oe, vv, took;
    logic [7:0] lock_code;
    logic [31:0] out_data, msk;
    logic [9:0] setup_m;
    logic [23:0] q[$];
    int error_cnt, tests_run, cyc, seed_dummy;
    // ============================================================
    // clock, 125 MHz
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    afepg_host_model host (.sys_clk(sys_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));
    afepg_regs dut (.sys_clk(sys_clk), .rst(rst), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .burst_next_addr(burst_next_addr),
        .restart_active_adcs(restart), .pair23_delay_code(p23), .pair01_delay_code(p01),
        .channel_gain_code(gcode), .channel_gain_log2(glog), .comm_checksum_enable(crc_en),
        .crc_word_32(crc32), .chan_ready_pulse(chan_ready_pulse),
        .config_checksum_error(err_in), .lock_code(lock_code), .sample_in_valid(in_valid),
        .sample_in_ready(in_ready), .sample_in_data(s), .sample_out_valid(out_valid),
        .sample_out_ready(out_ready), .sample_out_data(out_data),
        .sample_ready_pin_o(pin_o), .sample_ready_pin_oe(pin_oe));
    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            $display("[FAIL] %0t timeout", $time);
            finish_test();
        end
    end
    // expected formatting of one sample word
    function automatic logic [31:0] fmt(input logic [1:0] m, input logic [23:0] x);
        case (m)
            2'h3: fmt = {{8{x[23]}}, x};
            2'h2: fmt = {x, 8'h00};
            2'h1: fmt = {8'h00, x};
            default: fmt = {16'h0000, (x[23:8] == 16'h7fff) ? 16'h7fff : x[23:8] + x[7]};
        endcase
    endfunction
    // read and compare one register word
    task automatic rd_chk(input logic [4:0] a, input logic [23:0] e);
        host.rd(a, rdv, vv);
        `CHK(vv, 1'b1, "no read answer")
        `CHK(rdv, e, "read data")
    endtask
    // status read; flags return to not ready
    task automatic rd_status();
        rd_chk(afepg_pkg::STATUS_ADDR, {setup_m, 8'h00, flags_m});
        flags_m = 6'h3f;
    endtask
    // converter ready events and the pin answer
    task automatic pulse(input logic [5:0] m, input logic low);
        @(negedge sys_clk);
        chan_ready_pulse = m;
        flags_m = flags_m & ~m;
        @(negedge sys_clk);
        chan_ready_pulse = 6'h00;
        `CHK(pin_o, ~low, "pin level")
        `CHK(pin_oe, low | setup_m[6], "pin drive")
        @(negedge sys_clk);
        `CHK(pin_o, 1'b1, "pin idle")
        `CHK(pin_oe, setup_m[6], "pin idle drive")
    endtask
    // one offered sample, kept in the model when accepted
    task automatic push(input logic [23:0] x);
        @(negedge sys_clk);
        took = in_ready;
        in_valid = 1'b1;
        s = x;
        @(negedge sys_clk);
        in_valid = 1'b0;
        s = ~x;
        if (took) q.push_back(x);
        `CHK(out_valid, q.size() > 0, "out valid")
    endtask
    // take the head sample and compare its formatting
    task automatic pop_chk();
        @(negedge sys_clk);
        msk = (setup_m[3:2] == 2'h0) ? 32'h0000ffff : 32'hffffffff;
        `CHK(out_valid, 1'b1, "no sample")
        `CHK(out_data & msk, fmt(setup_m[3:2], q[0]) & msk, "sample format")
        out_ready = 1'b1;
        @(negedge sys_clk);
        out_ready = 1'b0;
        void'(q.pop_front());
    endtask
    // ============================================================
    // main sequence
    initial begin
        rst = 1'b1;
        chan_ready_pulse = 6'h00;
        err_in = 1'b0;
        lock_code = 8'h00;
        in_valid = 1'b0;
        out_ready = 1'b0;
        s = 24'h000000;
        setup_m = 10'h2a4;
        flags_m = 6'h3f;
        seed_dummy = $urandom(14);
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        `CHK({pin_o, pin_oe, in_ready, out_valid}, 4'b1010, "reset outputs")
        rd_chk(afepg_pkg::PHASE_ADDR, 24'h000000);
        rd_chk(afepg_pkg::GAIN_ADDR, 24'h000000);
        rd_chk(afepg_pkg::STATUS_ADDR, 24'ha9003f);
        // merged pulse waits for the last channel
        for (int i = 0; i < 6; i++) pulse(6'h01 << i, i == 5);
        rd_status();
        setup_m = 10'h2c4;
        host.wr(afepg_pkg::STATUS_ADDR, {setup_m, 14'h0000});
        pulse(6'h04, 1'b1);
        pulse(6'h21, 1'b1);
        rd_status();
        rd_status();
        // phase write and converter restart
        d = 24'($urandom);
        host.wr(afepg_pkg::PHASE_ADDR, d);
        `CHK(restart, 1'b1, "restart")
        `CHK(p23, d[23:12], "pair23 code")
        `CHK(p01, d[11:0], "pair01 code")
        @(negedge sys_clk);
        `CHK(restart, 1'b0, "restart length")
        rd_chk(afepg_pkg::PHASE_ADDR, d);
        // every gain code on every channel
        for (int c = 0; c < 8; c++) begin
            for (int j = 0; j < 6; j++) begin
                g[3*j +: 3] = 3'((c + j) % 8);
                lg[3*j +: 3] = ((c + j) % 8 <= 5) ? 3'((c + j) % 8) : 3'h0;
            end
            d = 24'($urandom);
            host.wr(afepg_pkg::GAIN_ADDR, {d[23:18], g});
            `CHK(gcode, g, "gain code")
            `CHK(glog, lg, "gain value")
            rd_chk(afepg_pkg::GAIN_ADDR, {6'h00, g});
        end
        // read and write increment modes with each data width
        for (int m = 0; m < 4; m++) begin
            d = 24'($urandom);
            setup_m = {m[1:0], m[0], 1'b1, 1'b0, d[0], m[1:0], d[1], 1'b0};
            host.wr(afepg_pkg::STATUS_ADDR, {setup_m, d[13:0]});
            `CHK(crc_en, d[1], "checksum enable")
            `CHK(crc32, d[0], "checksum width")
            rd_status();
            rd_chk(5'h1f, 24'h000000);
            `CHK(burst_next_addr, m == 3 ? 5'h00 : m == 2 ? 5'h10 : m == 1 ? 5'h1c : 5'h1f,
                "read burst")
            host.wr(5'h1f, d);
            `CHK(burst_next_addr, m[0] ? 5'h09 : 5'h1f, "write burst")
            d = 24'($urandom);
            if (m == 0) d[23] = 1'b0;
            push(d);
            pop_chk();
        end
        // checksum alert holds the pin low until unlocked
        host.wr(afepg_pkg::STATUS_ADDR, {setup_m[9:1], 1'b1, 14'h0000});
        @(negedge sys_clk);
        err_in = 1'b1;
        @(negedge sys_clk);
        err_in = 1'b0;
        repeat (4) begin
            @(negedge sys_clk);
            `CHK({pin_o, pin_oe}, 2'b01, "alert pin")
        end
        lock_code = 8'ha5;
        repeat (3) @(negedge sys_clk);
        `CHK(pin_o, 1'b1, "alert cleared")
        lock_code = 8'h00;
        // fill until refused, then drain with stalls
        for (int i = 0; i < 9; i++) push(24'($urandom));
        `CHK(in_ready, 1'b0, "fifo full")
        `CHK(q.size(), 8, "fifo depth")
        while (q.size() > 0) begin
            repeat ($urandom % 3) @(negedge sys_clk);
            pop_chk();
        end
        @(negedge sys_clk);
        `CHK(out_valid, 1'b0, "fifo empty")
        finish_test();
    end
endmodule
